/* design/mirq_core.sv */
// Interrupt flag and enable registers of a single-phase metering device.
// Assumes event pulses from the metrology datapath on CLK, and pulse
// output pins that are asynchronous and must be synchronised here.
`timescale 1ns/1ns

// Function
// (R01) Set no-load flags 15,14,13 on reactive, apparent, active no-load transitions.
// (R02) Set flag 12 on each fresh temperature reading.
// (R03) Set flag 11 on each overcurrent rms refresh.
// (R04) Set flag 10 when power accumulations refresh after programmed sample count.
// (R05) Set flag 9 when new waveform samples are ready.
// (R06) Set flag 8 on energy refresh, samples or line cycles by timer select.
// (R07) Set flags 7 and 6 on falling edge of second and first pulse outputs.
// (R08) Set flags 5 and 4 when pulse sign differs from previous pulse.
// (R09) Set flag 2 on reactive power sign change at accumulation refresh.
// (R10) Set flag 0 on active power sign change at same refresh timing.
// (R11) Enable bit 31 routes interrupt while any chip status flag is set.
// (R12) Enable bit 30 routes interrupt while any event status flag is set.
// (R13) Enable bit 29 routes interrupt while any autocal status flag is set.
// (R14) Enable bit 25 routes interrupt on power factor refresh every 1.024 s.
// (R15) Enable bit 24 routes interrupt when configuration checksum changes.
// (R16) Enable bit 23 routes interrupt when forced checksum computation finishes.
// (R17) Enable bit 21 routes interrupt on voltage zero-crossing timeout.
// (R18) Enable bit 20 routes interrupt on current B zero crossing.
// (R19) Summary bit 31 follows chip status; cleared when chip status read.
// (R20) Enable bit 19 routes interrupt on current A zero crossing.
// (R21) Flags clear only on write-one; zero leaves them; reserved read zero.
// (R22) Interrupt asserted while any flag and its enable are both set.
module mirq_core (
	// Clock and reset
	input wire logic CLK,
	input wire logic RST,
	// Register port
	input wire logic [11:0] REG_ADDR,
	input wire logic REG_WR,
	input wire logic REG_RD,
	input wire logic [31:0] REG_WDATA,
	output logic [31:0] REG_RDATA,
	// Summary inputs from other status registers
	input wire logic CHIP_STATUS_ANY,
	input wire logic CHIP_STATUS_READ,
	input wire logic EVENT_STATUS_ANY,
	input wire logic AUTOCAL_IRQ_ANY,
	// One-cycle event pulses from the metrology datapath
	input wire logic POWER_FACTOR_READY,
	input wire logic CONFIG_CHECKSUM_CHANGED,
	input wire logic CONFIG_CHECKSUM_DONE,
	input wire logic VOLTAGE_CROSSING_TIMEOUT,
	input wire logic CURRENT_B_CROSSING,
	input wire logic CURRENT_A_CROSSING,
	input wire logic REACTIVE_NOLOAD_CHANGE,
	input wire logic APPARENT_NOLOAD_CHANGE,
	input wire logic ACTIVE_NOLOAD_CHANGE,
	input wire logic TEMPERATURE_READY,
	input wire logic OVERCURRENT_RMS_UPDATE,
	input wire logic POWER_ACCUM_UPDATE,
	input wire logic WAVEFORM_SAMPLE_READY,
	input wire logic ENERGY_SAMPLE_TICK,
	input wire logic ENERGY_CYCLE_TICK,
	input wire logic ENERGY_TIMER_SELECT,
	// Signs of the new power accumulation and of each pulse's energy
	input wire logic REACTIVE_POWER_NEG,
	input wire logic ACTIVE_POWER_NEG,
	input wire logic FIRST_PULSE_ENERGY_NEG,
	input wire logic SECOND_PULSE_ENERGY_NEG,
	// Pulse output pins, asynchronous
	input wire logic FIRST_PULSE_OUTPUT,
	input wire logic SECOND_PULSE_OUTPUT,
	// Interrupt request, active low
	output logic IRQ_N
);
	import mirq_pkg::*;

	// ************************************************************
	// Pulse pin synchronisers and edge detect
	// ************************************************************
	logic [1:0] pin_meta;
	logic [1:0] pin_sync;
	logic [1:0] pin_last;
	logic [1:0] pin_fall;
	logic [1:0] pulse_neg_prev;
	logic [1:0] pulse_neg_now;
	logic react_neg_prev;
	logic active_neg_prev;
	logic energy_tick;
	logic flags_wr;
	logic enable_wr;
	logic [31:0] flags;
	logic [31:0] enable;
	logic [31:0] set_vec;
	logic [31:0] flags_view;
	logic [31:0] next_flags;

	always_ff @(posedge CLK) begin
		if (RST) begin
			pin_meta <= 2'h3;
			pin_sync <= 2'h3;
			pin_last <= 2'h3;
		end else begin
			pin_meta <= {SECOND_PULSE_OUTPUT, FIRST_PULSE_OUTPUT};
			pin_sync <= pin_meta;
			pin_last <= pin_sync;
		end
	end

	// High-to-low marks an issued pulse
	assign pin_fall = pin_last & ~pin_sync; // [R07]
	assign pulse_neg_now = {SECOND_PULSE_ENERGY_NEG, FIRST_PULSE_ENERGY_NEG};

	// Previous pulse sign, one per output
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_sign
			always_ff @(posedge CLK) begin
				if (RST) begin
					pulse_neg_prev[gi] <= 1'b0;
				end else if (pin_fall[gi]) begin
					pulse_neg_prev[gi] <= pulse_neg_now[gi]; // [R08]
				end
			end
		end
	endgenerate

	// ************************************************************
	// Power sign tracking
	// ************************************************************
	always_ff @(posedge CLK) begin
		if (RST) begin
			react_neg_prev <= 1'b0;
			active_neg_prev <= 1'b0;
		end else if (POWER_ACCUM_UPDATE) begin
			react_neg_prev <= REACTIVE_POWER_NEG; // [R09]
			active_neg_prev <= ACTIVE_POWER_NEG; // [R10]
		end
	end

	// Energy refresh counted in samples or line cycles
	assign energy_tick = ENERGY_TIMER_SELECT ? ENERGY_CYCLE_TICK : ENERGY_SAMPLE_TICK; // [R06]

	// ************************************************************
	// Set vector of sticky flags
	// ************************************************************
	always_comb begin
		set_vec = 32'h00000000;
		set_vec[MIRQ_PF_BIT] = POWER_FACTOR_READY; // [R14]
		set_vec[MIRQ_CONFIG_CHECKSUM_CHANGED_BIT] = CONFIG_CHECKSUM_CHANGED; // [R15]
		set_vec[MIRQ_CRC_DONE_BIT] = CONFIG_CHECKSUM_DONE; // [R16]
		set_vec[MIRQ_ZX_TIMEOUT_BIT] = VOLTAGE_CROSSING_TIMEOUT; // [R17]
		set_vec[MIRQ_ZX_B_BIT] = CURRENT_B_CROSSING; // [R18]
		set_vec[MIRQ_ZX_A_BIT] = CURRENT_A_CROSSING; // [R20]
		set_vec[MIRQ_REACT_NL_BIT] = REACTIVE_NOLOAD_CHANGE; // [R01]
		set_vec[MIRQ_APPAR_NL_BIT] = APPARENT_NOLOAD_CHANGE; // [R01]
		set_vec[MIRQ_ACTIVE_NL_BIT] = ACTIVE_NOLOAD_CHANGE; // [R01]
		set_vec[MIRQ_TEMP_BIT] = TEMPERATURE_READY; // [R02]
		set_vec[MIRQ_OC_RMS_BIT] = OVERCURRENT_RMS_UPDATE; // [R03]
		set_vec[MIRQ_PWR_BIT] = POWER_ACCUM_UPDATE; // [R04]
		set_vec[MIRQ_SAMPLE_BIT] = WAVEFORM_SAMPLE_READY; // [R05]
		set_vec[MIRQ_ENERGY_BIT] = energy_tick; // [R06]
		set_vec[MIRQ_PULSE2_BIT] = pin_fall[1]; // [R07]
		set_vec[MIRQ_PULSE1_BIT] = pin_fall[0]; // [R07]
		set_vec[MIRQ_FLIP2_BIT] = pin_fall[1] & (pulse_neg_now[1] ^ pulse_neg_prev[1]); // [R08]
		set_vec[MIRQ_FLIP1_BIT] = pin_fall[0] & (pulse_neg_now[0] ^ pulse_neg_prev[0]); // [R08]
		set_vec[MIRQ_REACT_SIGN_BIT] = POWER_ACCUM_UPDATE & (REACTIVE_POWER_NEG ^ react_neg_prev); // [R09]
		set_vec[MIRQ_ACTIVE_SIGN_BIT] = POWER_ACCUM_UPDATE & (ACTIVE_POWER_NEG ^ active_neg_prev); // [R10]
	end

	// ************************************************************
	// Flag and enable registers
	// ************************************************************
	assign flags_wr = REG_WR & (REG_ADDR == MIRQ_FLAGS_ADDR);
	assign enable_wr = REG_WR & (REG_ADDR == MIRQ_ENABLE_ADDR);

	// Set beats a simultaneous write-one, so no event is lost
	always_comb begin
		next_flags = flags;
		if (flags_wr) begin
			next_flags = flags & ~(REG_WDATA & MIRQ_W1C_MASK); // [R21]
		end
		next_flags = (next_flags | set_vec) & MIRQ_W1C_MASK; // [R21]
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			flags <= MIRQ_FLAGS_RESET;
		end else begin
			flags <= next_flags;
		end
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			enable <= MIRQ_ENABLE_RESET;
		end else if (enable_wr) begin
			enable <= REG_WDATA & MIRQ_ENABLE_WMASK;
		end
	end

	// Summary bits are live levels from the other status registers;
	// bit 31 is also masked here while CHIP_STATUS_READ is high.
	always_comb begin
		flags_view = flags;
		flags_view[MIRQ_CHIP_BIT] = CHIP_STATUS_ANY & ~CHIP_STATUS_READ; // [R19]
		flags_view[MIRQ_EVENT_BIT] = EVENT_STATUS_ANY;
		flags_view[MIRQ_AUTOCAL_BIT] = AUTOCAL_IRQ_ANY;
	end

	// ************************************************************
	// Read data and interrupt
	// ************************************************************
	always_ff @(posedge CLK) begin
		if (RST) begin
			REG_RDATA <= 32'h00000000;
		end else if (REG_RD && REG_ADDR == MIRQ_FLAGS_ADDR) begin
			REG_RDATA <= flags_view;
		end else if (REG_RD && REG_ADDR == MIRQ_ENABLE_ADDR) begin
			REG_RDATA <= enable;
		end else if (REG_RD) begin
			REG_RDATA <= 32'h00000000;
		end
	end

	// Chip summary enable is read-only in the map, so it routes whenever
	// the chip status has a flag and CHIP_STATUS_READ is low; this keeps that source reachable.
	always_ff @(posedge CLK) begin
		if (RST) begin
			IRQ_N <= 1'b1;
		end else begin
			IRQ_N <= ~(|(flags_view & (enable | (32'h1 << MIRQ_CHIP_BIT)) & MIRQ_ENABLE_RMASK)); // [R11] [R12] [R13] [R22]
		end
	end

endmodule

/* inc/mirq_pkg.sv */
// Package for the metering interrupt status and enable block.
// Assumes a single 20 MHz system clock and a 32-bit register port.
package mirq_pkg;

	// ************************************************************
	// Register map (word addresses)
	// ************************************************************
	localparam logic [11:0] MIRQ_FLAGS_ADDR = 12'h402;
	localparam logic [11:0] MIRQ_ENABLE_ADDR = 12'h405;
	localparam logic [31:0] MIRQ_FLAGS_RESET = 32'h00000000;
	localparam logic [31:0] MIRQ_ENABLE_RESET = 32'h00000000;

	// ************************************************************
	// Flag bit positions
	// ************************************************************
	localparam int MIRQ_CHIP_BIT = 31;
	localparam int MIRQ_EVENT_BIT = 30;
	localparam int MIRQ_AUTOCAL_BIT = 29;
	localparam int MIRQ_PF_BIT = 25;
	localparam int MIRQ_CONFIG_CHECKSUM_CHANGED_BIT = 24;
	localparam int MIRQ_CRC_DONE_BIT = 23;
	localparam int MIRQ_ZX_TIMEOUT_BIT = 21;
	localparam int MIRQ_ZX_B_BIT = 20;
	localparam int MIRQ_ZX_A_BIT = 19;
	localparam int MIRQ_REACT_NL_BIT = 15;
	localparam int MIRQ_APPAR_NL_BIT = 14;
	localparam int MIRQ_ACTIVE_NL_BIT = 13;
	localparam int MIRQ_TEMP_BIT = 12;
	localparam int MIRQ_OC_RMS_BIT = 11;
	localparam int MIRQ_PWR_BIT = 10;
	localparam int MIRQ_SAMPLE_BIT = 9;
	localparam int MIRQ_ENERGY_BIT = 8;
	localparam int MIRQ_PULSE2_BIT = 7;
	localparam int MIRQ_PULSE1_BIT = 6;
	localparam int MIRQ_FLIP2_BIT = 5;
	localparam int MIRQ_FLIP1_BIT = 4;
	localparam int MIRQ_REACT_SIGN_BIT = 2;
	localparam int MIRQ_ACTIVE_SIGN_BIT = 0;

	// Sticky write-one-to-clear bits kept in this block
	localparam logic [31:0] MIRQ_W1C_MASK = 32'h03B8FFF5;
	// Writable enable bits; bit 31 is read-only per the map
	localparam logic [31:0] MIRQ_ENABLE_WMASK = 32'h63B8FFF5;
	// Enable bits that can ever route an interrupt
	localparam logic [31:0] MIRQ_ENABLE_RMASK = 32'hE3B8FFF5;

endpackage

/* testbench/mirq_core_properties.sv */
// Checker for the metering interrupt flag and enable block.
// Assumes the bench keeps one idle cycle between register accesses.
`timescale 1ns/1ns
module mirq_props
	import mirq_pkg::*;
(
	// Clock and reset
	input wire logic CLK,
	input wire logic RST,
	// Register port
	input wire logic [11:0] REG_ADDR,
	input wire logic REG_WR,
	input wire logic REG_RD,
	input wire logic [31:0] REG_WDATA,
	input wire logic [31:0] REG_RDATA,
	// Watched sources and interrupt
	input wire logic CHIP_STATUS_ANY,
	input wire logic CHIP_STATUS_READ,
	input wire logic TEMPERATURE_READY,
	input wire logic POWER_ACCUM_UPDATE,
	input wire logic IRQ_N
);
	default clocking @(posedge CLK); endclocking
	default disable iff (RST);
	wire rf = REG_RD && REG_ADDR == MIRQ_FLAGS_ADDR;
	wire re = REG_RD && REG_ADDR == MIRQ_ENABLE_ADDR;
	property p_rd_hold; !REG_RD |=> $stable(REG_RDATA); endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("read data moved without a read");
	property p_rsv; rf |=> (REG_RDATA & 32'h1C47000A) == 32'h0; endproperty
	a_rsv: assert property (p_rsv) else $error("reserved flag bit read as one");
	property p_unmapped; REG_RD && !rf && !re |=> REG_RDATA == 32'h0; endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_en_rd; REG_WR && REG_ADDR == MIRQ_ENABLE_ADDR ##2 re |=> REG_RDATA == ($past(REG_WDATA, 3) & 32'h63B8FFF5);
	endproperty
	a_en_rd: assert property (p_en_rd) else $error("enable readback wrong");
	property p_temp; TEMPERATURE_READY ##2 rf |=> REG_RDATA[12]; endproperty
	a_temp: assert property (p_temp) else $error("temperature flag not set");
	property p_pwr; POWER_ACCUM_UPDATE ##2 rf |=> REG_RDATA[10]; endproperty
	a_pwr: assert property (p_pwr) else $error("power ready flag not set");
	property p_chip; CHIP_STATUS_ANY && !CHIP_STATUS_READ && rf |=> REG_RDATA[31]; endproperty
	a_chip: assert property (p_chip) else $error("chip summary not shown");
	property p_chip_rd; CHIP_STATUS_READ && rf |=> !REG_RDATA[31]; endproperty
	a_chip_rd: assert property (p_chip_rd) else $error("chip summary not masked on read");
	property p_irq_chip; (CHIP_STATUS_ANY && !CHIP_STATUS_READ)[*3] |-> !IRQ_N; endproperty
	a_irq_chip: assert property (p_irq_chip) else $error("chip summary did not interrupt");
	c_temp: cover property (TEMPERATURE_READY ##2 rf);
	c_irq: cover property ($fell(IRQ_N));
	c_chip_rd: cover property (CHIP_STATUS_READ && rf);
endmodule
bind mirq_core mirq_props u_props (.CLK(CLK), .RST(RST), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_RD(REG_RD),
	.REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .CHIP_STATUS_ANY(CHIP_STATUS_ANY),
	.CHIP_STATUS_READ(CHIP_STATUS_READ), .TEMPERATURE_READY(TEMPERATURE_READY),
	.POWER_ACCUM_UPDATE(POWER_ACCUM_UPDATE), .IRQ_N(IRQ_N));

/* testbench/tb_mirq_core.sv */
// Self-checking bench for the metering interrupt flag and enable block.
// Assumes the checker is bound in; pulse pins idle high.
`timescale 1ns/1ns
module tb_mirq_core;
	import mirq_pkg::*;
	logic CLK = 0, RST = 1, wr = 0, rd = 0, csa = 0, csr = 0, esa = 0, aca = 0, sel = 0;
	logic rneg = 0, aneg = 0, n1 = 0, n2 = 0, p1 = 1, p2 = 1, irq_n;
	logic [11:0] addr = 12'h000;
	logic [31:0] wd = 32'h00000000, rdata;
	logic [14:0] ev = 15'h0000;
	int miscompares = 0, comparisons = 0;
	localparam int EVB[14] = '{25, 24, 23, 21, 20, 19, 15, 14, 13, 12, 11, 10, 9, 8};
	always #25 CLK = ~CLK;
	mirq_core dut (.CLK(CLK), .RST(RST), .REG_ADDR(addr), .REG_WR(wr), .REG_RD(rd), .REG_WDATA(wd), .REG_RDATA(rdata),
		.CHIP_STATUS_ANY(csa), .CHIP_STATUS_READ(csr), .EVENT_STATUS_ANY(esa), .AUTOCAL_IRQ_ANY(aca),
		.POWER_FACTOR_READY(ev[0]), .CONFIG_CHECKSUM_CHANGED(ev[1]), .CONFIG_CHECKSUM_DONE(ev[2]),
		.VOLTAGE_CROSSING_TIMEOUT(ev[3]), .CURRENT_B_CROSSING(ev[4]), .CURRENT_A_CROSSING(ev[5]),
		.REACTIVE_NOLOAD_CHANGE(ev[6]), .APPARENT_NOLOAD_CHANGE(ev[7]), .ACTIVE_NOLOAD_CHANGE(ev[8]),
		.TEMPERATURE_READY(ev[9]), .OVERCURRENT_RMS_UPDATE(ev[10]), .POWER_ACCUM_UPDATE(ev[11]),
		.WAVEFORM_SAMPLE_READY(ev[12]), .ENERGY_SAMPLE_TICK(ev[13]), .ENERGY_CYCLE_TICK(ev[14]),
		.ENERGY_TIMER_SELECT(sel), .REACTIVE_POWER_NEG(rneg), .ACTIVE_POWER_NEG(aneg),
		.FIRST_PULSE_ENERGY_NEG(n1), .SECOND_PULSE_ENERGY_NEG(n2), .FIRST_PULSE_OUTPUT(p1),
		.SECOND_PULSE_OUTPUT(p2), .IRQ_N(irq_n));
	// ************************************************************
	// Shared tasks
	// ************************************************************
	task automatic end_sim;
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		comparisons++;
		if (s !== e) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
		@(posedge CLK);
		addr <= a;
		wd <= d;
		wr <= 1'b1;
		@(posedge CLK);
		wr <= 1'b0;
	endtask
	// Idle cycle before each access keeps the checker's spacing fixed
	task automatic rd_chk(input string n, input logic [11:0] a, input logic [31:0] e);
		@(posedge CLK);
		addr <= a;
		rd <= 1'b1;
		@(posedge CLK);
		rd <= 1'b0;
		#1 chk(n, e, rdata);
	endtask
	task automatic pulse(input int i);
		@(posedge CLK);
		ev[i] <= 1'b1;
		@(posedge CLK);
		ev <= 15'h0000;
	endtask
	task automatic wait_irq(input logic e);
		int k;
		k = 0;
		while (irq_n !== e && k < 4) begin
			@(posedge CLK);
			#1 k++;
		end
		chk("irq_n", {31'h0, e}, {31'h0, irq_n});
		if (irq_n !== e)
			end_sim();
	endtask
	// ************************************************************
	// Scenarios
	// ************************************************************
	task automatic t_regs;
		rd_chk("flags", MIRQ_FLAGS_ADDR, 32'h0);
		rd_chk("unmapped", 12'h400, 32'h0);
		wr_reg(MIRQ_ENABLE_ADDR, 32'hFFFFFFFF);
		rd_chk("enable", MIRQ_ENABLE_ADDR, 32'h63B8FFF5);
		wr_reg(MIRQ_ENABLE_ADDR, 32'h0);
	endtask
	task automatic t_events;
		for (int i = 0; i < 14; i++) begin
			pulse(i);
			rd_chk("event flag", MIRQ_FLAGS_ADDR, 32'h1 << EVB[i]);
			wr_reg(MIRQ_FLAGS_ADDR, ~(32'h1 << EVB[i]));
			rd_chk("kept flag", MIRQ_FLAGS_ADDR, 32'h1 << EVB[i]);
			wr_reg(MIRQ_FLAGS_ADDR, 32'h1 << EVB[i]);
			rd_chk("cleared", MIRQ_FLAGS_ADDR, 32'h0);
		end
		pulse(14);
		rd_chk("cycle tick ignored", MIRQ_FLAGS_ADDR, 32'h0);
		sel <= 1'b1;
		pulse(13);
		rd_chk("sample tick ignored", MIRQ_FLAGS_ADDR, 32'h0);
		pulse(14);
		rd_chk("cycle tick", MIRQ_FLAGS_ADDR, 32'h00000100);
		wr_reg(MIRQ_FLAGS_ADDR, 32'hFFFFFFFF);
	endtask
	task automatic t_signs;
		aneg <= 1'b1;
		pulse(11);
		rd_chk("active sign", MIRQ_FLAGS_ADDR, 32'h00000401);
		wr_reg(MIRQ_FLAGS_ADDR, 32'hFFFFFFFF);
		rneg <= 1'b1;
		pulse(11);
		rd_chk("reactive sign", MIRQ_FLAGS_ADDR, 32'h00000404);
		wr_reg(MIRQ_FLAGS_ADDR, 32'hFFFFFFFF);
	endtask
	task automatic t_pins;
		n1 <= 1'b1;
		p1 <= 1'b0;
		repeat (6) @(posedge CLK);
		p1 <= 1'b1;
		rd_chk("first pulse", MIRQ_FLAGS_ADDR, 32'h00000050);
		wr_reg(MIRQ_FLAGS_ADDR, 32'hFFFFFFFF);
		n2 <= 1'b1;
		p2 <= 1'b0;
		repeat (6) @(posedge CLK);
		p2 <= 1'b1;
		rd_chk("second pulse", MIRQ_FLAGS_ADDR, 32'h000000A0);
		wr_reg(MIRQ_FLAGS_ADDR, 32'hFFFFFFFF);
	endtask
	task automatic t_irq;
		pulse(9);
		repeat (3) @(posedge CLK);
		#1 chk("irq masked", 32'h1, {31'h0, irq_n});
		wr_reg(MIRQ_ENABLE_ADDR, 32'h00001000);
		wait_irq(1'b0);
		wr_reg(MIRQ_FLAGS_ADDR, 32'h00001000);
		wait_irq(1'b1);
		csa <= 1'b1;
		wait_irq(1'b0);
		rd_chk("chip summary", MIRQ_FLAGS_ADDR, 32'h80000000);
		csr <= 1'b1;
		rd_chk("chip summary read", MIRQ_FLAGS_ADDR, 32'h0);
		csa <= 1'b0;
		csr <= 1'b0;
		wait_irq(1'b1);
		esa <= 1'b1;
		aca <= 1'b1;
		wait_irq(1'b1);
		wr_reg(MIRQ_ENABLE_ADDR, 32'h40000000);
		wait_irq(1'b0);
		wr_reg(MIRQ_ENABLE_ADDR, 32'h20000000);
		rd_chk("summaries", MIRQ_FLAGS_ADDR, 32'h60000000);
		wait_irq(1'b0);
	endtask
	initial begin
		repeat (6) @(posedge CLK);
		RST <= 1'b0;
		t_regs();
		t_events();
		t_signs();
		t_pins();
		t_irq();
		end_sim();
	end
endmodule
